// [common/test_signal_router_map.svh]
`ifndef TEST_SIGNAL_ROUTER_MAP_SVH
`define TEST_SIGNAL_ROUTER_MAP_SVH

// register offsets
`define TSR_OFF_CLK_PROBE   8'h31
`define TSR_OFF_GROUP_PRBS  8'h32
`define TSR_OFF_AUX_EN      8'h33
`define TSR_OFF_OBSERVE     8'h35

// reset values
`define TSR_RST_CLK_PROBE   8'h00
`define TSR_RST_GROUP_PRBS  8'h00
`define TSR_RST_AUX_EN      8'h80
`define TSR_RST_UNMAPPED    8'h00

// field positions
`define TSR_CSRC_HI         5
`define TSR_CSRC_LO         4
`define TSR_CLK_TO_PIN      3
`define TSR_BITSEL_HI       2
`define TSR_BITSEL_LO       0
`define TSR_PRBS9_EN        6
`define TSR_PRBS15_EN       5
`define TSR_GSEL_HI         4
`define TSR_GSEL_LO         0
`define TSR_AUX_EN          7

// companion clock sources
`define TSR_SRC_OFF         2'h0
`define TSR_SRC_OSC         2'h1
`define TSR_SRC_UART        2'h2
`define TSR_SRC_RF          2'h3

// pseudo-random generator: taps and seed
`define TSR_P9_OUT          8
`define TSR_P9_TAP          4
`define TSR_P15_OUT         14
`define TSR_P15_TAP         13
`define TSR_LFSR_SEED       15'h7fff

`endif

// [common/test_signal_router_pkg.sv]
package test_signal_router_pkg;

	// generator sequence states
	typedef enum logic [1:0] {
		PRBS_IDLE,
		PRBS_ARMED,
		PRBS_SENDING
	} prbs_state_t;

	// one register bus request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	// thirty-two internal test buses of eight bits
	typedef logic [31:0][7:0] test_groups_t;

	// pin synchroniser chains: osc, uart, rf, strap
	typedef logic [3:0][2:0] sync_chain_t;

	// whole state of the router
	typedef struct packed {
		logic [7:0]  cfg_clk_probe;
		logic [7:0]  cfg_group_prbs;
		logic [7:0]  cfg_aux_en;
		logic [7:0]  rdata;
		sync_chain_t sync;
		logic [3:0]  filt;
		logic        cclk;
		logic        strap_out;
		logic        strap_oe;
		logic        probe;
		logic        aux_a;
		logic        aux_a_oe;
		logic        aux_b;
		logic        aux_b_oe;
		prbs_state_t prbs_state;
		logic        sending;
		logic [14:0] lfsr;
		logic        prbs_bit;
	} router_state_t;

endpackage

// [design/test_signal_router.sv]
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`include "test_signal_router_map.svh"

// Contract
// R1 - source field picks companion clock source
// R2 - bit 3 drives clock onto strap pin
// R3 - bit select drives one bus bit
// R4 - group select feeds probe and readback
// R5 - observe register reads live selected bus
// R6 - bit 6 enables PRBS9 generator
// R7 - bit 5 enables PRBS15 generator
// R8 - sequence waits for send command
// R9 - host configures transmitter before enabling
// R10 - bit 7 low disables aux lines
// R11 - host writes zero to spare bits; the bench writes random values to 0x31, spare bits 7:6 included
// R12 - host enables one PRBS mode only
module test_signal_router (
	// clock, enable, reset
	input  wire logic                                clk,
	input  wire logic                                clk_en,
	input  wire logic                                reset,
	// register port
	input  wire test_signal_router_pkg::reg_req_t    reg_req,
	output logic [7:0]                               reg_rdata,
	// companion clock sources, asynchronous
	input  wire logic                                osc_clk_in,
	input  wire logic                                uart_clk_in,
	input  wire logic                                rf_clk_in,
	output logic                                     companion_clock_out,
	// address strap pin, two-way
	input  wire logic                                addr_strap_bit5_in,
	output logic                                     addr_strap_bit5_out,
	output logic                                     addr_strap_bit5_oe,
	output logic                                     addr_strap_value,
	// internal test buses and probe pin
	input  wire test_signal_router_pkg::test_groups_t test_groups,
	output logic                                     signal_probe_out,
	// transmitter side of the pattern generator
	input  wire logic                                send_cmd,
	input  wire logic                                tx_bit_strobe,
	output logic                                     prbs_sending,
	output logic                                     prbs_bit,
	// uart auxiliary lines
	input  wire logic                                uart_aux_line_a_in,
	input  wire logic                                uart_aux_line_b_in,
	output logic                                     uart_aux_line_a,
	output logic                                     uart_aux_line_a_oe,
	output logic                                     uart_aux_line_b,
	output logic                                     uart_aux_line_b_oe
);

	// all state lives here
	test_signal_router_pkg::router_state_t st_r;
	test_signal_router_pkg::router_state_t st_nxt;

	// decoded fields of the configuration registers and other internal signals
	logic [1:0] clk_src;     // companion clock source
	logic       clk_to_pin;  // clock onto strap pin
	logic [2:0] bit_sel;     // probe bit of the bus
	logic [4:0] group_sel;   // chosen test bus
	logic       prbs9_en;    // short sequence enable
	logic       prbs15_en;   // long sequence enable
	logic       aux_en;      // aux lines enable
	logic [7:0] sel_bus;     // live selected test bus
	logic [3:0] pins;        // raw asynchronous inputs
	logic       cclk_sel;    // selected filtered clock
	logic       prbs_any;    // either mode enabled

	// address match, shared by read and write decode
	function automatic logic reg_hit(
		input logic [7:0] addr,
		input logic [7:0] off
	);
		reg_hit = (addr == off);
	endfunction

	// field decode
	assign clk_src    = st_r.cfg_clk_probe[`TSR_CSRC_HI:`TSR_CSRC_LO];
	assign clk_to_pin = st_r.cfg_clk_probe[`TSR_CLK_TO_PIN];
	assign bit_sel    = st_r.cfg_clk_probe[`TSR_BITSEL_HI:`TSR_BITSEL_LO];
	assign group_sel  = st_r.cfg_group_prbs[`TSR_GSEL_HI:`TSR_GSEL_LO];
	assign prbs9_en   = st_r.cfg_group_prbs[`TSR_PRBS9_EN];
	assign prbs15_en  = st_r.cfg_group_prbs[`TSR_PRBS15_EN];
	assign aux_en     = st_r.cfg_aux_en[`TSR_AUX_EN];
	assign prbs_any   = prbs9_en | prbs15_en;

	// R4 group select
	assign sel_bus = test_groups[group_sel];

	// order matches the synchroniser chain index
	assign pins = {addr_strap_bit5_in, rf_clk_in, uart_clk_in, osc_clk_in};

	// R1 source select
	always_comb begin
		case (clk_src)
			`TSR_SRC_OFF: begin
				// held at ground
				cclk_sel = 1'b0;
			end
			`TSR_SRC_OSC: begin
				cclk_sel = st_r.filt[0];
			end
			`TSR_SRC_UART: begin
				cclk_sel = st_r.filt[1];
			end
			`TSR_SRC_RF: begin
				cclk_sel = st_r.filt[2];
			end
			default: begin
				cclk_sel = 1'b0;
			end
		endcase
	end

	// next-state logic of the whole block
	always_comb begin
		st_nxt = st_r;

		// synchronisers: the first stage feeds only the second
		for (int i = 0; i < 4; i++) begin
			st_nxt.sync[i] = {st_r.sync[i][1:0], pins[i]};
			// a change counts once stages two and three agree
			if (st_r.sync[i][1] == st_r.sync[i][2]) begin
				st_nxt.filt[i] = st_r.sync[i][2];
			end
		end

		// register writes; spare bits are stored as written
		if (reg_req.wr) begin
			if (reg_hit(reg_req.addr, `TSR_OFF_CLK_PROBE)) begin
				st_nxt.cfg_clk_probe = reg_req.wdata;
			end
			if (reg_hit(reg_req.addr, `TSR_OFF_GROUP_PRBS)) begin
				st_nxt.cfg_group_prbs = reg_req.wdata;
			end
			if (reg_hit(reg_req.addr, `TSR_OFF_AUX_EN)) begin
				st_nxt.cfg_aux_en = reg_req.wdata;
			end
		end

		// read data stands only in the cycle after the strobe
		st_nxt.rdata = `TSR_RST_UNMAPPED;
		if (reg_req.rd) begin
			if (reg_hit(reg_req.addr, `TSR_OFF_CLK_PROBE)) begin
				st_nxt.rdata = st_r.cfg_clk_probe;
			end else if (reg_hit(reg_req.addr, `TSR_OFF_GROUP_PRBS)) begin
				st_nxt.rdata = st_r.cfg_group_prbs;
			end else if (reg_hit(reg_req.addr, `TSR_OFF_AUX_EN)) begin
				st_nxt.rdata = st_r.cfg_aux_en;
			end else if (reg_hit(reg_req.addr, `TSR_OFF_OBSERVE)) begin
				// R5 live bus readback
				st_nxt.rdata = sel_bus;
			end
		end

		// companion clock; sampled at 40 MHz it is only a coarse copy
		st_nxt.cclk = cclk_sel;

		// R2 strap pin drive
		st_nxt.strap_oe  = clk_to_pin;
		st_nxt.strap_out = clk_to_pin & cclk_sel;

		// R3 probe bit
		st_nxt.probe = sel_bus[bit_sel];

		// R10 aux line gating: a disabled line is released and low
		st_nxt.aux_a    = aux_en & uart_aux_line_a_in;
		st_nxt.aux_b    = aux_en & uart_aux_line_b_in;
		st_nxt.aux_a_oe = aux_en;
		st_nxt.aux_b_oe = aux_en;

		// pattern generator sequence
		case (st_r.prbs_state)
			test_signal_router_pkg::PRBS_IDLE: begin
				st_nxt.prbs_bit = 1'b0;
				// R6 R7 enable arms the generator
				if (prbs_any) begin
					st_nxt.lfsr       = `TSR_LFSR_SEED;
					st_nxt.prbs_state = test_signal_router_pkg::PRBS_ARMED;
				end
			end
			test_signal_router_pkg::PRBS_ARMED: begin
				// R8 wait for send
				if (!prbs_any) begin
					st_nxt.prbs_state = test_signal_router_pkg::PRBS_IDLE;
				end else if (send_cmd) begin
					st_nxt.prbs_state = test_signal_router_pkg::PRBS_SENDING;
				end
			end
			test_signal_router_pkg::PRBS_SENDING: begin
				if (!prbs_any) begin
					st_nxt.prbs_bit   = 1'b0;
					st_nxt.prbs_state = test_signal_router_pkg::PRBS_IDLE;
				end else if (tx_bit_strobe) begin
					// both set is undefined; the short one wins here
					if (prbs9_en) begin
						// R6 x9 + x5 + 1
						st_nxt.prbs_bit = st_r.lfsr[`TSR_P9_OUT];
						st_nxt.lfsr = {st_r.lfsr[13:0],
							st_r.lfsr[`TSR_P9_OUT] ^ st_r.lfsr[`TSR_P9_TAP]};
					end else begin
						// R7 x15 + x14 + 1
						st_nxt.prbs_bit = st_r.lfsr[`TSR_P15_OUT];
						st_nxt.lfsr = {st_r.lfsr[13:0],
							st_r.lfsr[`TSR_P15_OUT] ^ st_r.lfsr[`TSR_P15_TAP]};
					end
				end
			end
			default: begin
				st_nxt.prbs_state = test_signal_router_pkg::PRBS_IDLE;
			end
		endcase

		// busy flag kept in its own flop so the pin shows no decode glitch
		st_nxt.sending = (st_nxt.prbs_state ==
			test_signal_router_pkg::PRBS_SENDING);
	end

	// state register; clock enable low freezes everything
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_r                <= '0;
			st_r.cfg_clk_probe  <= `TSR_RST_CLK_PROBE;
			st_r.cfg_group_prbs <= `TSR_RST_GROUP_PRBS;
			st_r.cfg_aux_en     <= `TSR_RST_AUX_EN;
			st_r.prbs_state     <= test_signal_router_pkg::PRBS_IDLE;
			st_r.lfsr           <= `TSR_LFSR_SEED;
			// aux lines come up enabled, so their drivers too
			st_r.aux_a_oe       <= 1'b1;
			st_r.aux_b_oe       <= 1'b1;
		end else if (clk_en) begin
			st_r <= st_nxt;
		end
	end

	// outputs straight from the state flops
	assign reg_rdata           = st_r.rdata;
	assign companion_clock_out = st_r.cclk;
	assign addr_strap_bit5_out = st_r.strap_out;
	assign addr_strap_bit5_oe  = st_r.strap_oe;
	assign addr_strap_value    = st_r.filt[3];
	assign signal_probe_out    = st_r.probe;
	assign prbs_sending        = st_r.sending;
	assign prbs_bit            = st_r.prbs_bit;
	assign uart_aux_line_a     = st_r.aux_a;
	assign uart_aux_line_a_oe  = st_r.aux_a_oe;
	assign uart_aux_line_b     = st_r.aux_b;
	assign uart_aux_line_b_oe  = st_r.aux_b_oe;

	// checks, all on clk and disabled in reset
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// R1 off source
	property p_src_off;
		clk_en && clk_src == `TSR_SRC_OFF |=> !companion_clock_out;
	endproperty
	a_src_off: assert property (p_src_off) // R1
		else $error("companion clock not grounded");

	// R1 rf source
	property p_src_rf;
		clk_en && clk_src == `TSR_SRC_RF
			|=> companion_clock_out == $past(st_r.filt[2]);
	endproperty
	a_src_rf: assert property (p_src_rf) // R1
		else $error("companion clock not from rf source");

	// R2 strap drive
	property p_strap_drive;
		clk_en |=> addr_strap_bit5_oe == $past(clk_to_pin)
			&& (!addr_strap_bit5_oe
			|| addr_strap_bit5_out == companion_clock_out);
	endproperty
	a_strap_drive: assert property (p_strap_drive) // R2
		else $error("strap pin not carrying companion clock");

	// R3 probe bit
	property p_probe_bit;
		clk_en |=> signal_probe_out == $past(sel_bus[bit_sel]);
	endproperty
	a_probe_bit: assert property (p_probe_bit) // R3
		else $error("probe pin shows wrong bus bit");

	// R4 shared group
	property p_shared_group;
		clk_en && reg_req.rd && reg_hit(reg_req.addr, `TSR_OFF_OBSERVE)
			|=> reg_rdata[$past(bit_sel)] == signal_probe_out;
	endproperty
	a_shared_group: assert property (p_shared_group) // R4
		else $error("probe and readback use different buses");

	// R5 live readback
	property p_observe;
		clk_en && reg_req.rd && reg_hit(reg_req.addr, `TSR_OFF_OBSERVE)
			|=> reg_rdata == $past(test_groups[group_sel]);
	endproperty
	a_observe: assert property (p_observe) // R5
		else $error("observe read not the live bus");

	// R6 short sequence step
	property p_prbs9;
		clk_en && prbs_sending && prbs9_en && tx_bit_strobe
			|=> prbs_bit == $past(st_r.lfsr[8])
			&& st_r.lfsr[0] == $past(st_r.lfsr[8] ^ st_r.lfsr[4]);
	endproperty
	a_prbs9: assert property (p_prbs9) // R6
		else $error("short sequence step wrong");

	// R7 long sequence step
	property p_prbs15;
		clk_en && prbs_sending && !prbs9_en && prbs15_en && tx_bit_strobe
			|=> prbs_bit == $past(st_r.lfsr[14])
			&& st_r.lfsr[0] == $past(st_r.lfsr[14] ^ st_r.lfsr[13]);
	endproperty
	a_prbs15: assert property (p_prbs15) // R7
		else $error("long sequence step wrong");

	// R8 start only on send
	property p_send_start;
		$rose(prbs_sending) |-> $past(send_cmd && clk_en && prbs_any);
	endproperty
	a_send_start: assert property (p_send_start) // R8
		else $error("sequence began without send command");

	// R10 aux gating
	property p_aux_gate;
		clk_en ##1 !uart_aux_line_a_oe |-> !uart_aux_line_a
			&& !uart_aux_line_b_oe && !$past(aux_en);
	endproperty
	a_aux_gate: assert property (p_aux_gate) // R10
		else $error("aux lines active while disabled");

	// R10 enabled lines pass through
	property p_aux_pass;
		clk_en && aux_en |=> uart_aux_line_a_oe && uart_aux_line_b_oe
			&& uart_aux_line_a == $past(uart_aux_line_a_in)
			&& uart_aux_line_b == $past(uart_aux_line_b_in);
	endproperty
	a_aux_pass: assert property (p_aux_pass) // R10
		else $error("enabled aux lines not passed through");

	// main scenarios
	c_strap_clock: cover property (addr_strap_bit5_oe
		&& addr_strap_bit5_out);
	c_prbs_run: cover property (prbs_sending && tx_bit_strobe
		&& clk_en);
	c_aux_off: cover property (!uart_aux_line_a_oe);

endmodule

// [tb/test_test_signal_router.sv]
`timescale 1ns/1ps
`include "test_signal_router_map.svh"

// one compare: counts it, reports and counts a miss
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin \
	$display("mismatch %s exp %h got %h", n, e, g); err_total++; end end

module test_test_signal_router;
	// bench-driven inputs
	logic                                 clk;
	logic                                 clk_en;
	logic                                 reset;
	test_signal_router_pkg::reg_req_t     req;
	test_signal_router_pkg::test_groups_t tg;
	logic                                 osc, uart, rf, strap_in;
	logic                                 send_cmd, strobe;
	logic                                 aux_a_in, aux_b_in;
	// observed outputs
	logic [7:0]                           rdata;
	logic                                 cclk, strap_out, strap_oe, strap_val;
	logic                                 probe, sending, pbit;
	logic                                 aux_a, aux_a_oe, aux_b, aux_b_oe;
	// bench state
	int                                   err_total, cmp_count, n, m, g, b;
	logic [1:0]                           src;
	logic [3:0]                           div;
	logic [14:0]                          lf;
	logic [7:0]                           v;

	test_signal_router i_test_signal_router (
		.clk(clk), .clk_en(clk_en), .reset(reset),
		.reg_req(req), .reg_rdata(rdata),
		.osc_clk_in(osc), .uart_clk_in(uart), .rf_clk_in(rf),
		.companion_clock_out(cclk),
		.addr_strap_bit5_in(strap_in), .addr_strap_bit5_out(strap_out),
		.addr_strap_bit5_oe(strap_oe), .addr_strap_value(strap_val),
		.test_groups(tg), .signal_probe_out(probe),
		.send_cmd(send_cmd), .tx_bit_strobe(strobe),
		.prbs_sending(sending), .prbs_bit(pbit),
		.uart_aux_line_a_in(aux_a_in), .uart_aux_line_b_in(aux_b_in),
		.uart_aux_line_a(aux_a), .uart_aux_line_a_oe(aux_a_oe),
		.uart_aux_line_b(aux_b), .uart_aux_line_b_oe(aux_b_oe)
	);

	// 40 MHz system clock
	always #12.5 clk = ~clk;

	// only the source under test toggles, so a wrong pick stays flat
	always @(posedge clk) begin
		div  <= div + 4'h1;
		osc  <= (src == `TSR_SRC_OSC) & div[2];
		uart <= (src == `TSR_SRC_UART) & div[2];
		rf   <= (src == `TSR_SRC_RF) & div[2];
	end

	// watchdog: a hang counts as a miss
	initial begin
		repeat (100000) @(posedge clk);
		err_total++;
		tally_and_finish;
	end

	task automatic tally_and_finish;
		$display("errors %0d compares %0d", err_total, cmp_count);
		if (err_total == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// settle a few edges, then step off the edge
	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	// one-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{a, d, 1'b1, 1'b0};
		@(posedge clk);
		req <= '0;
	endtask

	// one-cycle read strobe; data stands only in the next cycle
	task automatic rd(input logic [7:0] a, input logic [7:0] e,
		input string nm);
		@(posedge clk);
		req <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk);
		req <= '0;
		#1 `CHK(nm, e, rdata)
	endtask

	// count rising edges on the clock output and the strap pin
	task automatic rises;
		logic pc, ps;
		n = 0;
		m = 0;
		pc = cclk;
		ps = strap_out;
		repeat (40) begin
			cyc(1);
			if (cclk && !pc) n++;
			if (strap_out && !ps) m++;
			pc = cclk;
			ps = strap_out;
		end
	endtask

	// arm a generator, hold it until send, then walk the sequence
	task automatic prbs(input logic [7:0] en, input int o, input int t);
		wr(`TSR_OFF_GROUP_PRBS, en);
		cyc(4);
		`CHK("sending_early", 1'b0, sending)
		@(posedge clk);
		send_cmd <= 1'b1;
		@(posedge clk);
		send_cmd <= 1'b0;
		cyc(1);
		`CHK("sending", 1'b1, sending)
		lf = `TSR_LFSR_SEED;
		for (int i = 0; i < 48; i++) begin
			@(posedge clk);
			strobe <= 1'b1;
			@(posedge clk);
			strobe <= 1'b0;
			#1 `CHK("prbs_bit", lf[o], pbit)
			lf = {lf[13:0], lf[o] ^ lf[t]};
		end
		wr(`TSR_OFF_GROUP_PRBS, 8'h00);
		cyc(2);
		`CHK("stopped", 2'b00, {sending, pbit})
	endtask

	initial begin
		clk = 1'b0;
		clk_en = 1'b1;
		reset = 1'b1;
		req = '0;
		tg = '0;
		src = 2'h0;
		div = 4'h0;
		{osc, uart, rf, strap_in, send_cmd, strobe} = '0;
		{aux_a_in, aux_b_in} = 2'b00;
		err_total = 0;
		cmp_count = 0;
		v = 8'($urandom(32'ha59b));
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		cyc(1);
		// reset values, then an unmapped place
		`CHK("aux_oe_rst", 2'b11, {aux_a_oe, aux_b_oe})
		rd(`TSR_OFF_CLK_PROBE, 8'h00, "rst31");
		rd(`TSR_OFF_GROUP_PRBS, 8'h00, "rst32");
		rd(`TSR_OFF_AUX_EN, 8'h80, "rst33");
		rd(8'h34, 8'h00, "unmapped");
		// a write while the clock enable is low must be lost
		@(posedge clk);
		clk_en <= 1'b0;
		wr(`TSR_OFF_CLK_PROBE, 8'h0f);
		@(posedge clk);
		clk_en <= 1'b1;
		rd(`TSR_OFF_CLK_PROBE, 8'h00, "frozen");
		repeat (6) begin
			v = 8'($urandom);
			wr(`TSR_OFF_CLK_PROBE, v);
			wr(`TSR_OFF_GROUP_PRBS, v & 8'h1f);
			wr(`TSR_OFF_AUX_EN, v & 8'h80);
			rd(`TSR_OFF_CLK_PROBE, v, "rb31");
			rd(`TSR_OFF_GROUP_PRBS, v & 8'h1f, "rb32");
			rd(`TSR_OFF_AUX_EN, v & 8'h80, "rb33");
		end
		// probe path: first trial is the top group and top bit
		for (int i = 0; i < 12; i++) begin
			@(posedge clk);
			for (int k = 0; k < 32; k++) tg[k] <= 8'($urandom);
			g = (i == 0) ? 31 : $urandom_range(31, 0);
			b = (i == 0) ? 7 : $urandom_range(7, 0);
			wr(`TSR_OFF_CLK_PROBE, 8'(b));
			wr(`TSR_OFF_GROUP_PRBS, 8'(g));
			rd(`TSR_OFF_OBSERVE, tg[g], "observe");
			`CHK("probe", tg[g][b], probe)
		end
		// aux lines, disabled and enabled, every input pair
		for (int e = 0; e < 2; e++) begin
			wr(`TSR_OFF_AUX_EN, e[0] ? 8'h80 : 8'h00);
			for (int k = 0; k < 4; k++) begin
				@(posedge clk);
				{aux_a_in, aux_b_in} <= k[1:0];
				cyc(2);
				v = {4'h0, k[1] & e[0], k[0] & e[0], e[0], e[0]};
				`CHK("aux", v[3:0], {aux_a, aux_b, aux_a_oe, aux_b_oe})
			end
		end
		// every clock source, routed to the strap pin
		for (int s = 0; s < 4; s++) begin
			@(posedge clk);
			src <= s[1:0];
			wr(`TSR_OFF_CLK_PROBE, {2'b00, s[1:0], 1'b1, 3'b000});
			cyc(6);
			rises;
			`CHK("cclk_runs", s != 0, n != 0)
			`CHK("strap_runs", s != 0, m != 0)
			`CHK("strap_oe", 1'b1, strap_oe)
		end
		wr(`TSR_OFF_CLK_PROBE, 8'h30);
		cyc(3);
		`CHK("strap_oe_off", 1'b0, strap_oe)
		// strap pin level read back through its synchroniser
		`CHK("strap_low", 1'b0, strap_val)
		@(posedge clk);
		strap_in <= 1'b1;
		cyc(5);
		`CHK("strap_value", 1'b1, strap_val)
		// send while idle is ignored
		@(posedge clk);
		send_cmd <= 1'b1;
		@(posedge clk);
		send_cmd <= 1'b0;
		cyc(2);
		`CHK("idle_send", 1'b0, sending)
		prbs(8'h40, `TSR_P9_OUT, `TSR_P9_TAP);
		prbs(8'h20, `TSR_P15_OUT, `TSR_P15_TAP);
		tally_and_finish;
	end
endmodule
